// *** rtl/pwm_timer.sv ***
// Sixteen-bit PWM timer with two channels behind an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Edge-aligned mode counts up only; period is modulus plus one counts.
// - Edge-aligned PWM works with center select clear beside capture/compare channels.
// - Polarity A clear: overflow drives high, match drives low; set inverts both.
// - Value zero gives 0% duty; value above modulus gives 100% duty.
// - Channel value byte writes land in buffers, not the active compare value.
// - Clock off loads on second byte; compare mode at next tick; PWM at modulus-minus-one to modulus step.
// - Center mode counts up to modulus and down to zero, period twice modulus.
// - Center mode: zero or negative value 0%; value above modulus 100%.
// - Center mode, polarity clear: match counting up low, counting down high.
// - Center mode buffers modulus high and channel value bytes, loaded coherently.
// - Overflow interrupt may be raised at end of the count equal to modulus.
// - Writing timer status/control discards pending modulus bytes.
// - Writing channel status/control discards that channel's pending value bytes.
// - Reset clears status/control, mode, polarity bits; pins released, clock off.
// - Channel flag sets on each match in compare/edge PWM, on a match with a pin action in center PWM, on selected edge in capture.
// - Overflow flag sets as the counter leaves its terminal count.
// - Interrupt requests are static: flag and local enable both set.
// - Flag clears by read while set then write zero; new event keeps it.
// - Clock select 00 off, 01 bus, 10 fixed clock, 11 external.
// - Up/down: zero and terminal count last one count; flag sets turning down.
// - Up counter runs zero to terminal count, modulus or 0xFFFF, then wraps.
module pwm_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fixed_clk_tick,
  input wire logic ext_clk_tick,
  input wire logic [1:0] ch_in,
  output logic [1:0] ch_out,
  output logic [1:0] ch_oe,
  output logic irq_overflow,
  output logic [1:0] irq_channel
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Two-step flag update: a new event always wins over the clearing write.
  function automatic logic flag_next(input logic cur, input logic armed, input logic event_in,
                                     input logic wr_zero);
    flag_next = event_in | (cur & ~(armed & wr_zero));
  endfunction

  // Arming for the clear: set by a read of the flag at one, dropped by events or writes.
  function automatic logic arm_next(input logic armed, input logic flag, input logic rd,
                                    input logic event_in, input logic wr);
    arm_next = ~event_in & ((rd & flag) | (armed & ~wr));
  endfunction

  // Channel register address decode: returns the channel index hit, or -1.
  function automatic int ch_hit(input logic [7:0] addr, input logic [7:0] ofs);
    ch_hit = -1;
    for (int i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin
      if (addr == 8'(pwm_timer_pkg::ADDR_CH_BASE + 8'(i) * pwm_timer_pkg::CH_STRIDE + ofs)) begin
        ch_hit = i;
      end
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] tsc_r;
  logic tof_armed_r;
  logic [15:0] cnt_r;
  pwm_timer_pkg::dir_t dir_r;
  logic [6:0] pre_r;
  logic [15:0] mod_r;
  logic [7:0] mod_buf_hi_r;
  logic [7:0] mod_buf_lo_r;
  logic mod_got_hi_r;
  logic mod_got_lo_r;
  logic [7:0] csc_r [pwm_timer_pkg::NUM_CH];
  logic chf_armed_r [pwm_timer_pkg::NUM_CH];
  logic [15:0] val_r [pwm_timer_pkg::NUM_CH];
  logic [7:0] val_buf_hi_r [pwm_timer_pkg::NUM_CH];
  logic [7:0] val_buf_lo_r [pwm_timer_pkg::NUM_CH];
  logic val_got_hi_r [pwm_timer_pkg::NUM_CH];
  logic val_got_lo_r [pwm_timer_pkg::NUM_CH];
  logic [1:0] ch_in_prev_r;
  logic [1:0] out_r;

  // AXI bookkeeping.
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic wr_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ************************************************************
  // Bus handshake decode
  // ************************************************************

  // One write and one read in flight; each address or data beat is taken once.
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_got_r & w_got_r & ~bvalid_r;
  wire wr_en = do_wr & wr_lane_r;
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready = ~w_got_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Write targets; only byte lane 0 holds data, other lanes are dropped.
  wire wr_tsc = wr_en & (wr_addr_r == pwm_timer_pkg::ADDR_TIMER_SC);
  wire wr_cnt = wr_en & ((wr_addr_r == pwm_timer_pkg::ADDR_CNT_HIGH) |
                         (wr_addr_r == pwm_timer_pkg::ADDR_CNT_LOW));
  wire wr_mod_hi = wr_en & (wr_addr_r == pwm_timer_pkg::ADDR_MOD_HIGH);
  wire wr_mod_lo = wr_en & (wr_addr_r == pwm_timer_pkg::ADDR_MOD_LOW);
  wire rd_tsc = ar_hs & (s_axi_araddr == pwm_timer_pkg::ADDR_TIMER_SC);
  int wr_ch_sc;
  int wr_ch_hi;
  int wr_ch_lo;
  int rd_ch_sc;
  int rd_ch_hi;
  int rd_ch_lo;
  assign wr_ch_sc = ch_hit(wr_addr_r, pwm_timer_pkg::CH_OFS_SC);
  assign wr_ch_hi = ch_hit(wr_addr_r, pwm_timer_pkg::CH_OFS_VAL_HIGH);
  assign wr_ch_lo = ch_hit(wr_addr_r, pwm_timer_pkg::CH_OFS_VAL_LOW);
  assign rd_ch_sc = ch_hit(s_axi_araddr, pwm_timer_pkg::CH_OFS_SC);
  assign rd_ch_hi = ch_hit(s_axi_araddr, pwm_timer_pkg::CH_OFS_VAL_HIGH);
  assign rd_ch_lo = ch_hit(s_axi_araddr, pwm_timer_pkg::CH_OFS_VAL_LOW);
  wire addr_ok_wr = (wr_addr_r <= pwm_timer_pkg::ADDR_MOD_LOW) & (wr_addr_r[1:0] == 2'b00) |
                    (wr_ch_sc >= 0) | (wr_ch_hi >= 0) | (wr_ch_lo >= 0);

  // ************************************************************
  // Counting clock and counter
  // ************************************************************

  wire [1:0] clk_sel = tsc_r[pwm_timer_pkg::TSC_CLK_HI:pwm_timer_pkg::TSC_CLK_LO];
  wire clk_off = (clk_sel == pwm_timer_pkg::CLK_OFF);
  wire src_en = (clk_sel == pwm_timer_pkg::CLK_BUS) |
                ((clk_sel == pwm_timer_pkg::CLK_FIXED) & fixed_clk_tick) |
                ((clk_sel == pwm_timer_pkg::CLK_EXT) & ext_clk_tick);
  wire [6:0] pre_last = 7'((8'h01 << tsc_r[pwm_timer_pkg::TSC_PS_HI:0]) - 8'h01);
  wire tick = src_en & (pre_r == pre_last);
  wire center = tsc_r[pwm_timer_pkg::TSC_CENTER];

  // terminal count is the modulus, or the full range when it is zero
  wire [15:0] term = (mod_r == pwm_timer_pkg::MOD_RESET) ? pwm_timer_pkg::CNT_MAX : mod_r;
  // reverse only on a non-zero modulus match
  wire turn_down = center & (dir_r == pwm_timer_pkg::DIR_UP) & (mod_r != pwm_timer_pkg::MOD_RESET) &
                   (cnt_r == mod_r);
  wire turn_up = center & (dir_r == pwm_timer_pkg::DIR_DOWN) & (cnt_r == 16'h0000);
  wire wrap = ~center & (cnt_r == term);
  logic [15:0] cnt_nxt;
  pwm_timer_pkg::dir_t dir_nxt;

  // up only when center select is clear; ends last one count each.
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (wrap) begin
      cnt_nxt = 16'h0000;
      dir_nxt = pwm_timer_pkg::DIR_UP;
    end else if (turn_down) begin
      cnt_nxt = 16'(cnt_r - 16'h0001);
      dir_nxt = pwm_timer_pkg::DIR_DOWN;
    end else if (turn_up | (dir_r == pwm_timer_pkg::DIR_UP) | ~center) begin
      cnt_nxt = 16'(cnt_r + 16'h0001);
      dir_nxt = pwm_timer_pkg::DIR_UP;
    end else begin
      cnt_nxt = 16'(cnt_r - 16'h0001);
    end
  end

  // overflow as the terminal count is left; end of the modulus count.
  wire tof_event = tick & (wrap | turn_down);
  // the buffered-value load point, modulus-minus-one to terminal count.
  wire load_point = tick & (cnt_nxt == term) & (cnt_r == 16'(term - 16'h0001));

  // Counter, prescaler and timer status/control; a counter write restarts both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // clock off, overflow interrupt off, center select clear
      tsc_r <= pwm_timer_pkg::TSC_RESET;
      tof_armed_r <= 1'b0;
      cnt_r <= 16'h0000;
      dir_r <= pwm_timer_pkg::DIR_UP;
      pre_r <= 7'h00;
    end else begin
      tsc_r[pwm_timer_pkg::TSC_FLAG] <= flag_next(tsc_r[pwm_timer_pkg::TSC_FLAG], tof_armed_r, tof_event,
                                                  wr_tsc & ~wr_data_r[pwm_timer_pkg::TSC_FLAG]);
      tof_armed_r <= arm_next(tof_armed_r, tsc_r[pwm_timer_pkg::TSC_FLAG], rd_tsc, tof_event, wr_tsc);
      if (wr_tsc) begin
        tsc_r[pwm_timer_pkg::TSC_IRQ_EN:0] <= wr_data_r[pwm_timer_pkg::TSC_IRQ_EN:0];
      end
      if (wr_cnt) begin
        cnt_r <= 16'h0000;
        dir_r <= pwm_timer_pkg::DIR_UP;
        pre_r <= 7'h00;
      end else if (src_en) begin
        pre_r <= tick ? 7'h00 : 7'(pre_r + 7'h01);
        if (tick) begin
          cnt_r <= cnt_nxt;
          dir_r <= dir_nxt;
        end
      end
    end
  end

  // ************************************************************
  // Modulus buffer
  // ************************************************************

  // both modulus bytes are buffered and loaded as one word.
  wire mod_full = mod_got_hi_r & mod_got_lo_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_r <= pwm_timer_pkg::MOD_RESET;
      mod_buf_hi_r <= 8'h00;
      mod_buf_lo_r <= 8'h00;
      mod_got_hi_r <= 1'b0;
      mod_got_lo_r <= 1'b0;
    end else if (wr_tsc) begin
      // status/control write cancels a half-written modulus
      mod_got_hi_r <= 1'b0;
      mod_got_lo_r <= 1'b0;
    end else begin
      if (wr_mod_hi) begin
        mod_buf_hi_r <= wr_data_r;
        mod_got_hi_r <= 1'b1;
      end
      if (wr_mod_lo) begin
        mod_buf_lo_r <= wr_data_r;
        mod_got_lo_r <= 1'b1;
      end
      // Loading on the next counter step lets a new period cut the current one short.
      if (mod_full & (clk_off | tick)) begin
        mod_r <= {mod_buf_hi_r, mod_buf_lo_r};
        mod_got_hi_r <= 1'b0;
        mod_got_lo_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Channels
  // ************************************************************
  logic [1:0] ch_event;
  logic [1:0] ch_match;
  logic [1:0] ch_level;
  logic [1:0] ch_edge_mode;
  logic [1:0] ch_compare_mode;
  logic [1:0] ch_capture_mode;
  logic [1:0] ch_pin_on;

  // Per-channel mode decode, compare match and target PWM level for the next count.
  always_comb begin
    for (int i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin
      ch_pin_on[i] = csc_r[i][pwm_timer_pkg::CSC_ELS_B] | csc_r[i][pwm_timer_pkg::CSC_ELS_A];
      // edge PWM only while center select is clear
      ch_edge_mode[i] = ~center & csc_r[i][pwm_timer_pkg::CSC_MODE_B];
      ch_compare_mode[i] = ~center & ~csc_r[i][pwm_timer_pkg::CSC_MODE_B] & csc_r[i][pwm_timer_pkg::CSC_MODE_A];
      ch_capture_mode[i] = ~center & ~csc_r[i][pwm_timer_pkg::CSC_MODE_B] & ~csc_r[i][pwm_timer_pkg::CSC_MODE_A];
      ch_match[i] = tick & (cnt_nxt == val_r[i]);
      // active while below the value, so zero never and above modulus always
      // zero or negative value holds inactive in center mode
      // up-count match ends the pulse, down-count match starts it
      ch_level[i] = ((dir_nxt == pwm_timer_pkg::DIR_DOWN) ? (cnt_nxt <= val_r[i]) : (cnt_nxt < val_r[i])) &
                    ~(center & (val_r[i][15] | (val_r[i] == 16'h0000)));
      // match in compare/edge PWM, match with a pin action in center PWM, selected edge in capture
      ch_event[i] = ch_capture_mode[i] ?
                    ((csc_r[i][pwm_timer_pkg::CSC_ELS_A] & ch_in[i] & ~ch_in_prev_r[i]) |
                     (csc_r[i][pwm_timer_pkg::CSC_ELS_B] & ~ch_in[i] & ch_in_prev_r[i])) :
                    ch_match[i] & (center ? ch_pin_on[i] : 1'b1);
    end
  end

  // Channel registers, value buffers and output flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_in_prev_r <= 2'b00;
      out_r <= 2'b00;
      for (int i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin
        // channels return to capture with pins released
        csc_r[i] <= pwm_timer_pkg::CSC_RESET;
        chf_armed_r[i] <= 1'b0;
        val_r[i] <= 16'h0000;
        val_buf_hi_r[i] <= 8'h00;
        val_buf_lo_r[i] <= 8'h00;
        val_got_hi_r[i] <= 1'b0;
        val_got_lo_r[i] <= 1'b0;
      end
    end else begin
      ch_in_prev_r <= ch_in;
      for (int i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin
        // channel flag two-step clear, a new event keeps it set
        csc_r[i][pwm_timer_pkg::CSC_FLAG] <= flag_next(csc_r[i][pwm_timer_pkg::CSC_FLAG], chf_armed_r[i],
          ch_event[i], (wr_ch_sc == i) & wr_en & ~wr_data_r[pwm_timer_pkg::CSC_FLAG]);
        chf_armed_r[i] <= arm_next(chf_armed_r[i], csc_r[i][pwm_timer_pkg::CSC_FLAG],
                                   ar_hs & (rd_ch_sc == i), ch_event[i], wr_en & (wr_ch_sc == i));
        if (wr_en & (wr_ch_sc == i)) begin
          csc_r[i][pwm_timer_pkg::CSC_IRQ_EN:0] <= wr_data_r[pwm_timer_pkg::CSC_IRQ_EN:0];
          // status/control write cancels half-written value bytes
          val_got_hi_r[i] <= 1'b0;
          val_got_lo_r[i] <= 1'b0;
        end else begin
          // bytes go to the buffer, never straight to the compare value
          if (wr_en & (wr_ch_hi == i)) begin
            val_buf_hi_r[i] <= wr_data_r;
            val_got_hi_r[i] <= 1'b1;
          end
          if (wr_en & (wr_ch_lo == i)) begin
            val_buf_lo_r[i] <= wr_data_r;
            val_got_lo_r[i] <= 1'b1;
          end
          // immediate with clock off, next tick in compare mode, otherwise at the load point
          // same load point for centered PWM
          if (val_got_hi_r[i] & val_got_lo_r[i] & ~ch_capture_mode[i] &
              (clk_off | (ch_compare_mode[i] ? tick : load_point))) begin
            val_r[i] <= {val_buf_hi_r[i], val_buf_lo_r[i]};
            val_got_hi_r[i] <= 1'b0;
            val_got_lo_r[i] <= 1'b0;
          end
        end
        // Capture latches the count on the selected edge.
        if (ch_capture_mode[i] & ch_event[i]) begin
          val_r[i] <= cnt_r;
        end
        // pin state changes only on counting ticks
        if (tick) begin
          if (center | ch_edge_mode[i]) begin
            // polarity bit A inverts the active level
            out_r[i] <= ch_level[i] ^ csc_r[i][pwm_timer_pkg::CSC_ELS_A];
          end else if (ch_compare_mode[i] & ch_match[i]) begin
            case ({csc_r[i][pwm_timer_pkg::CSC_ELS_B], csc_r[i][pwm_timer_pkg::CSC_ELS_A]})
              2'b01: out_r[i] <= ~out_r[i];
              2'b10: out_r[i] <= 1'b0;
              2'b11: out_r[i] <= 1'b1;
              default: out_r[i] <= out_r[i];
            endcase
          end
        end
      end
    end
  end

  // Pins are driven only by output channels with a pin action selected.
  always_comb begin
    for (int i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin
      ch_oe[i] = ch_pin_on[i] & ~ch_capture_mode[i];
      // static request while flag and enable are both set
      irq_channel[i] = csc_r[i][pwm_timer_pkg::CSC_FLAG] & csc_r[i][pwm_timer_pkg::CSC_IRQ_EN];
    end
  end
  assign ch_out = out_r;
  // overflow request follows its flag and enable
  assign irq_overflow = tsc_r[pwm_timer_pkg::TSC_FLAG] & tsc_r[pwm_timer_pkg::TSC_IRQ_EN];

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic [7:0] rd_byte;
  logic rd_ok;

  // Read mux; unmapped words answer SLVERR with zero data.
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (s_axi_araddr == pwm_timer_pkg::ADDR_TIMER_SC) begin
      rd_byte = tsc_r;
    end else if (s_axi_araddr == pwm_timer_pkg::ADDR_CNT_HIGH) begin
      rd_byte = cnt_r[15:8];
    end else if (s_axi_araddr == pwm_timer_pkg::ADDR_CNT_LOW) begin
      rd_byte = cnt_r[7:0];
    end else if (s_axi_araddr == pwm_timer_pkg::ADDR_MOD_HIGH) begin
      rd_byte = mod_r[15:8];
    end else if (s_axi_araddr == pwm_timer_pkg::ADDR_MOD_LOW) begin
      rd_byte = mod_r[7:0];
    end else if (rd_ch_sc >= 0) begin
      rd_byte = csc_r[rd_ch_sc[0]];
    end else if (rd_ch_hi >= 0) begin
      rd_byte = val_r[rd_ch_hi[0]][15:8];
    end else if (rd_ch_lo >= 0) begin
      rd_byte = val_r[rd_ch_lo[0]][7:0];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Write channel: address and data may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= pwm_timer_pkg::AXI_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wr_data_r <= s_axi_wdata[7:0];
        wr_lane_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok_wr ? pwm_timer_pkg::AXI_OKAY : pwm_timer_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: data registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= pwm_timer_pkg::UNMAPPED_READ;
      rresp_r <= pwm_timer_pkg::AXI_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_ok ? pwm_timer_pkg::AXI_OKAY : pwm_timer_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// *** common/pwm_timer_pkg.sv ***
// Package of register offsets, field positions and encodings for the PWM timer.
package pwm_timer_pkg;

  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] ADDR_TIMER_SC = 8'h00;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h08;
  localparam logic [7:0] ADDR_MOD_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_MOD_LOW = 8'h10;
  localparam logic [7:0] ADDR_CH_BASE = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_OFS_SC = 8'h00;
  localparam logic [7:0] CH_OFS_VAL_HIGH = 8'h04;
  localparam logic [7:0] CH_OFS_VAL_LOW = 8'h08;
  localparam int NUM_CH = 2;

  // ************************************************************
  // Field positions of timer_status_control
  // ************************************************************
  localparam int TSC_FLAG = 7;
  localparam int TSC_IRQ_EN = 6;
  localparam int TSC_CENTER = 5;
  localparam int TSC_CLK_HI = 4;
  localparam int TSC_CLK_LO = 3;
  localparam int TSC_PS_HI = 2;

  // ************************************************************
  // Field positions of channel_status_control
  // ************************************************************
  localparam int CSC_FLAG = 7;
  localparam int CSC_IRQ_EN = 6;
  localparam int CSC_MODE_B = 5;
  localparam int CSC_MODE_A = 4;
  localparam int CSC_ELS_B = 3;
  localparam int CSC_ELS_A = 2;

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [7:0] TSC_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_BUS = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT = 2'b11
  } clk_src_t;

  // Count direction of the up/down counter, one bit so Gray by nature.
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage

// *** verif/pwm_timer_assertions.sv ***
// Port-level checker for the PWM timer register bus and outputs.
`timescale 1ns/1ps
module pwm_timer_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] ch_out,
  input wire logic [1:0] ch_oe,
  input wire logic irq_overflow,
  input wire logic [1:0] irq_channel
);
  // ****
  // Checks, all in the bus clock domain.
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> ch_oe == 2'b00 && ch_out == 2'b00 &&
    !irq_overflow && irq_channel == 2'b00 && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not idle after reset");
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken busy");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
endmodule
bind pwm_timer pwm_timer_assertions pwm_timer_assertions_inst (.*);

// *** verif/pwm_load_model.sv ***
// Load on a channel pin that counts the cycles it is driven high.
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic aclk,
  input wire logic pin,
  input wire logic oe,
  input wire logic en,
  output int high_cnt
);
  // A released pin reads low through the load's pull-down.
  wire logic level = oe & pin;
  // Count only inside the window, so each window starts from zero.
  always @(posedge aclk) begin
    if (!en) high_cnt <= 0;
    // An unknown level adds a large count, so it never passes.
    else if (level !== 1'b0) high_cnt <= high_cnt + ((level === 1'b1) ? 1 : 4096);
  end
endmodule

// *** verif/pwm_timer_tb.sv ***
// Self-checking bench for the PWM timer.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %h %h", $time, a, b); end end
module pwm_timer_tb;
  // ****
  // Signals, design and load.
  // ****
  localparam logic [7:0] TSC = pwm_timer_pkg::ADDR_TIMER_SC;
  localparam logic [7:0] CSC = pwm_timer_pkg::ADDR_CH_BASE;
  localparam logic [7:0] VH = CSC + pwm_timer_pkg::CH_OFS_VAL_HIGH;
  localparam logic [7:0] VL = CSC + pwm_timer_pkg::CH_OFS_VAL_LOW;
  typedef struct { logic [7:0] sc; logic [7:0] v; int e; } row_t;
  row_t rows [4] = '{'{8'h28, 8'h04, 40}, '{8'h24, 8'h04, 60}, '{8'h28, 8'h00, 0}, '{8'h28, 8'h0b, 100}};
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, win = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, fixed_clk_tick = '0, ext_clk_tick = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] ch_in = '0, s_axi_bresp, s_axi_rresp, ch_out, ch_oe, irq_channel, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_overflow;
  int bad_count = 0, cmp_count = 0, high_cnt;
  pwm_timer pwm_timer_inst (.*);
  pwm_load_model pwm_load_model_inst (.aclk(aclk), .pin(ch_out[0]), .oe(ch_oe[0]), .en(win), .high_cnt(high_cnt));
  always #5 aclk = ~aclk;
  // Each bus task starts one edge after the last release, so no signal is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Open the load's counting window for n cycles.
  task automatic measure(input int n);
    repeat (25) @(posedge aclk);
    win <= 1'b1;
    repeat (n) @(posedge aclk);
    win <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wr(pwm_timer_pkg::ADDR_MOD_HIGH, 8'h00);
    wr(pwm_timer_pkg::ADDR_MOD_LOW, 8'h09);
    wr(TSC, 8'h08);
    // Edge-aligned duty over ten periods of ten counts.
    foreach (rows[i]) begin
      wr(CSC, rows[i].sc);
      wr(VH, 8'h00);
      wr(VL, rows[i].v);
      measure(100);
      `CHK(high_cnt, rows[i].e)
    end
    wr(CSC, 8'h68);
    `CHK(irq_channel, 2'b01)
    // Overflow flag: a new event between read and write keeps it.
    wr(TSC, 8'h48);
    `CHK(irq_overflow, 1'b1)
    rd_reg(TSC);
    `CHK(rd[7], 1'b1)
    repeat (12) @(posedge aclk);
    wr(TSC, 8'h40);
    `CHK(irq_overflow, 1'b1)
    rd_reg(TSC);
    wr(TSC, 8'h40);
    `CHK(irq_overflow, 1'b0)
    // Center-aligned: period 18, then negative value, then a discarded byte.
    // modulus 9, channel 0 centered.
    wr(TSC, 8'h20);
    wr(CSC, 8'h08);
    wr(VH, 8'h00);
    wr(VL, 8'h04);
    wr(TSC, 8'h28);
    measure(180);
    `CHK(high_cnt, 80)
    wr(VH, 8'h80);
    wr(VL, 8'h04);
    measure(180);
    `CHK(high_cnt, 0)
    wr(VH, 8'h00);
    wr(CSC, 8'h08);
    wr(VL, 8'h04);
    measure(180);
    `CHK(high_cnt, 0)
    // Second reset in mid-run, then reset values and an unmapped read.
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(TSC);
    `CHK(rd, 32'h00000000)
    rd_reg(CSC);
    `CHK(rd, 32'h00000000)
    `CHK(ch_oe, 2'b00)
    `CHK(ch_out, 2'b00)
    rd_reg(8'hfc);
    `CHK(rr, pwm_timer_pkg::AXI_SLVERR)
    wr(8'hfc, 8'h00);
    `CHK(rr, pwm_timer_pkg::AXI_SLVERR)
    tally_and_finish();
  end
endmodule
